// ==== pci_power_mgmt_config_regs.sv ====
// power-management control/status, extension and miscellaneous configuration registers
`timescale 1ns/1ps
`default_nettype none
module pci_power_mgmt_config_regs (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        perst_n,
  input  wire logic        global_reset_n,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  output logic             cfg_hit,
  output logic [1:0]       power_state,
  output logic             pm_rev_select,
  output logic             vendor_id_bit26,
  output logic             wake_ignores_master_irq_bit,
  output logic [1:0]       read_cmd_select,
  output logic             abort_disable,
  output logic             fundamental_reset_n
);
  //----------------------------------------------------------------------------
  // reset and storage
  //----------------------------------------------------------------------------
  logic [1:0]  power_state_field_q;
  logic        pm_revision_select_bit_q;
  logic        wake_ignores_q;
  logic [1:0]  read_cmd_q;
  logic        abort_dis_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        wr_pmcsr;
  logic        wr_misc_lo;
  logic        wr_misc_hi;
  logic [15:0] misc_low;
  logic [31:0] rd_word;
  logic        rd_hit;

  pm_fund_reset pm_fund_reset_inst (
    .mclk                (mclk),
    .perst_n             (perst_n),
    .global_reset_n      (global_reset_n),
    .fundamental_reset_n (fundamental_reset_n)
  );

  //----------------------------------------------------------------------------
  // write decode
  //----------------------------------------------------------------------------
  assign wr_pmcsr   = cfg_wr && (cfg_addr == pm_cfg_pkg::PMCSR_OFS) && cfg_be[0];
  assign wr_misc_lo = cfg_wr && (cfg_addr == pm_cfg_pkg::MISC_OFS) && cfg_be[0];
  assign wr_misc_hi = cfg_wr && (cfg_addr == pm_cfg_pkg::MISC_OFS) && cfg_be[1];

  // sticky fields sit on the fundamental reset only; the D3hot-to-D0 internal
  // reset (resetn) must not touch the power state
  always_ff @(posedge mclk or negedge fundamental_reset_n) begin
    if (!fundamental_reset_n) begin
      power_state_field_q      <= pm_cfg_pkg::POWER_STATE_RST;
      pm_revision_select_bit_q <= pm_cfg_pkg::MISC_B7_RST;
      read_cmd_q               <= pm_cfg_pkg::MISC_B98_RST;
      abort_dis_q              <= pm_cfg_pkg::MISC_B4_RST;
    end else begin
      if (wr_pmcsr) begin
        power_state_field_q <= cfg_wdata[1:0];
      end
      if (wr_misc_lo) begin
        pm_revision_select_bit_q <= cfg_wdata[pm_cfg_pkg::BIT_PM_REV];
        abort_dis_q              <= cfg_wdata[pm_cfg_pkg::BIT_DIS_ABORT];
      end
      if (wr_misc_hi) begin
        read_cmd_q <= cfg_wdata[9:8];
      end
    end
  end

  // bit 10 is not sticky, so it follows the ordinary reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wake_ignores_q <= pm_cfg_pkg::MISC_B10_RST;
    end else if (wr_misc_hi) begin
      wake_ignores_q <= cfg_wdata[pm_cfg_pkg::BIT_IGN_MASTER];
    end
  end

  //----------------------------------------------------------------------------
  // read path
  //----------------------------------------------------------------------------
  // bit 15 wake-from-cold 0, bits 14-12 zero, bit 11 one, bits 6-5 and 3-0 zero
  assign misc_low = {1'b0, 3'h0, pm_cfg_pkg::CONFORM_VALUE, wake_ignores_q, read_cmd_q,
                     pm_revision_select_bit_q, 2'h0, abort_dis_q, 4'h0};

  pm_rd_mux pm_rd_mux_inst (
    .cfg_addr          (cfg_addr),
    .power_state_field (power_state_field_q),
    .misc_low          (misc_low),
    .rd_word           (rd_word),
    .rd_hit            (rd_hit)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_rd;
      rdata_q  <= cfg_rd ? rd_word : 32'h0000_0000;
    end
  end

  assign cfg_rdata                   = rdata_q;
  assign cfg_rvalid                  = rvalid_q;
  assign cfg_hit                     = rd_hit;
  assign power_state                 = power_state_field_q;
  assign pm_rev_select               = pm_revision_select_bit_q;
  assign vendor_id_bit26             = wake_ignores_q;
  assign wake_ignores_master_irq_bit = wake_ignores_q;
  assign read_cmd_select             = read_cmd_q;
  assign abort_disable               = abort_dis_q;
endmodule : pci_power_mgmt_config_regs
`default_nettype wire

// ==== pci_power_mgmt_config_regs_tb.sv ====
// testbench for the power-management configuration registers
`timescale 1ns/1ps
`default_nettype none
module pci_power_mgmt_config_regs_tb;
  logic        mclk = 0, resetn = 0, perst_n = 0, global_reset_n = 0, cfg_wr = 0, cfg_rd = 0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, q;
  logic        cfg_rvalid, pm_rev_select, vendor_id_bit26, fundamental_reset_n;
  logic        cfg_hit, wake_ignores_master_irq_bit, abort_disable;
  logic [1:0]  power_state, read_cmd_select;
  int          n_fail = 0, checks_done = 0, cyc = 0;
  always #5 mclk = ~mclk;
  pci_power_mgmt_config_regs pci_power_mgmt_config_regs_inst (.mclk(mclk), .resetn(resetn), .perst_n(perst_n),
    .global_reset_n(global_reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_hit(cfg_hit),
    .power_state(power_state), .pm_rev_select(pm_rev_select), .vendor_id_bit26(vendor_id_bit26),
    .wake_ignores_master_irq_bit(wake_ignores_master_irq_bit), .read_cmd_select(read_cmd_select),
    .abort_disable(abort_disable), .fundamental_reset_n(fundamental_reset_n));
  // ----------------
  // tasks
  // ----------------
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge mclk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, d};
    @(negedge mclk);
    cfg_wr = 0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(negedge mclk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge mclk);
    cfg_rd = 0;
    q = cfg_rdata;
  endtask : rd
  // hang guard well above the 65 or so cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (3) @(negedge mclk);
    {resetn, perst_n, global_reset_n} = 3'b111;
    repeat (3) @(negedge mclk);
    rd(8'hF0); chk("misc", q, 32'h00000A90);
    rd(8'h48); chk("csr", q, 32'h0);
    rd(8'h4A); chk("ext", q, 32'h0);
    chk("hit_ext", 32'(cfg_hit), 32'h1);
    rd(8'h44); chk("unmapped", q, 32'h0);
    chk("hit_unmapped", 32'(cfg_hit), 32'h0);
    wr(8'h48, 4'hF, 32'hFFFFFFFF); rd(8'h48); chk("csr_ro", q, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(8'h48, 4'h1, 32'(i)); chk("pstate", 32'(power_state), 32'(i));
    end
    rd(8'h4A);
    chk("ext_hi", 32'(q[31:16]), 32'h0);
    wr(8'hF0, 4'hF, 32'hFFFFFFFF); rd(8'hF0); chk("misc_ro", q, 32'h00000F90);
    chk("mirror1", 32'(vendor_id_bit26), 32'h1);
    chk("mirror1_out", 32'(wake_ignores_master_irq_bit), 32'h1);
    rd(8'h46); chk("ver3", 32'(q[18:16]), 32'h3);
    wr(8'hF0, 4'hF, 32'h00000400); rd(8'hF0); chk("misc_w", q, 32'h00000C00);
    rd(8'h46); chk("ver2", 32'(q[18:16]), 32'h2);
    wr(8'h48, 4'h1, 32'h2);
    @(negedge mclk); resetn = 0;
    @(negedge mclk); resetn = 1;
    repeat (3) @(negedge mclk);
    chk("keep_ps", 32'(power_state), 32'h2);
    chk("keep_rev", 32'(pm_rev_select), 32'h0);
    chk("mirror0", 32'(vendor_id_bit26), 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(8'h48, 4'h1, 32'h1);
      @(negedge mclk); {perst_n, global_reset_n} = (k == 0) ? 2'b01 : 2'b10;
      @(negedge mclk); chk("fund", 32'(fundamental_reset_n), 32'h0);
      chk("fund_ps", 32'(power_state), 32'h0);
      chk("fund_rdcmd", 32'(read_cmd_select), 32'h2);
      chk("fund_abort", 32'(abort_disable), 32'h1);
      {perst_n, global_reset_n} = 2'b11;
      repeat (3) @(negedge mclk);
      rd(8'hF0); chk("misc_fund", q, 32'h00000A90);
    end
    summarize();
  end
endmodule : pci_power_mgmt_config_regs_tb
`default_nettype wire

// ==== pm_cfg_asserts.sv ====
// port assertions for the power-management configuration registers
`timescale 1ns/1ps
`default_nettype none
module pm_cfg_asserts (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        perst_n,
  input wire logic        global_reset_n,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic [1:0]  power_state,
  input wire logic        pm_rev_select,
  input wire logic        vendor_id_bit26,
  input wire logic        fundamental_reset_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------
  // properties
  // ----------------
  rd_answer_a: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered");
  no_stray_a: assert property (!cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0) else $error("stray read data");
  csr_ro_a: assert property (cfg_rd && cfg_addr == 8'h48 |=> cfg_rdata[31:2] == 30'h0)
    else $error("csr fixed bits wrong");
  misc_fixed_a: assert property (cfg_rd && cfg_addr == 8'hF0 |=> cfg_rdata[31:11] == 21'h1)
    else $error("misc fixed bits wrong");
  pstate_wr_a: assert property (cfg_wr && cfg_addr == 8'h48 && cfg_be[0] && fundamental_reset_n
    |=> power_state == $past(cfg_wdata[1:0])) else $error("power state not written");
  vendor_mirror_a: assert property (cfg_wr && cfg_addr == 8'hF0 && cfg_be[1]
    |=> vendor_id_bit26 == $past(cfg_wdata[10]))
    else $error("vendor bit mirror wrong");
  rev_wr_a: assert property (cfg_wr && cfg_addr == 8'hF0 && cfg_be[0] && fundamental_reset_n
    |=> pm_rev_select == $past(cfg_wdata[7])) else $error("revision select not written");
  fund_gen_a: assert property (!(perst_n && global_reset_n) |=> !fundamental_reset_n)
    else $error("no fundamental reset");
  sticky_dflt_a: assert property (!fundamental_reset_n |-> power_state == 2'h0 && pm_rev_select)
    else $error("sticky defaults wrong");
  cover property (cfg_rd && cfg_addr == 8'hF0);
  cover property (cfg_wr && cfg_addr == 8'h48);
  cover property (!fundamental_reset_n);
endmodule : pm_cfg_asserts
bind pci_power_mgmt_config_regs pm_cfg_asserts pm_cfg_asserts_inst (.mclk(mclk), .resetn(resetn), .perst_n(perst_n),
  .global_reset_n(global_reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .power_state(power_state),
  .pm_rev_select(pm_rev_select), .vendor_id_bit26(vendor_id_bit26), .fundamental_reset_n(fundamental_reset_n));
`default_nettype wire

// ==== pm_cfg_pkg.sv ====
// constants for the power-management and miscellaneous configuration registers
`default_nettype none
//------------------------------------------------------------------------------
// Notes on behaviour
// - two-bit power state: D0, D1, D2, D3
// - wake status and enable bits read zero
// - data scale and select fields read zero
// - control/status bits 7-2 read zero
// - extension register at 4Ah reads zero
// - misc register upper half reads zero
// - wake-from-cold bit hardwired zero
// - misc bits 14-12 read zero
// - bus revision conformance bit reads one
// - misc bit 10 mirrored to vendor bit 26
// - sticky bits reset to their defaults only by fundamental reset
// - fundamental reset from PERST or global reset
// - control/status survives D3hot-to-D0 internal reset
// - bit 7 selects version 010b or 011b
//------------------------------------------------------------------------------
package pm_cfg_pkg;
  localparam logic [7:0]  PMCSR_OFS       = 8'h48;
  localparam logic [7:0]  PM_EXT_OFS      = 8'h4A;
  localparam logic [7:0]  MISC_OFS        = 8'hF0;
  localparam logic [7:0]  PM_CAP_OFS      = 8'h46;
  localparam logic [1:0]  POWER_STATE_RST = 2'h0;
  localparam logic        MISC_B10_RST    = 1'b0;
  localparam logic        MISC_B7_RST     = 1'b1;
  localparam logic [1:0]  MISC_B98_RST    = 2'h2;
  localparam logic        MISC_B4_RST     = 1'b1;
  localparam logic [15:0] PM_EXT_VALUE    = 16'h0000;
  localparam logic        CONFORM_VALUE   = 1'b1;
  localparam logic [2:0]  PM_VER_OLD      = 3'h2;
  localparam logic [2:0]  PM_VER_NEW      = 3'h3;
  localparam logic [12:0] PM_CAP_UPPER    = 13'h0FC0;
  localparam int          BIT_CONFORM     = 11;
  localparam int          BIT_IGN_MASTER  = 10;
  localparam int          BIT_PM_REV      = 7;
  localparam int          BIT_DIS_ABORT   = 4;

  typedef enum logic [1:0] {
    PS_D0 = 2'b00,
    PS_D1 = 2'b01,
    PS_D2 = 2'b10,
    PS_D3 = 2'b11
  } power_state_t;
endpackage : pm_cfg_pkg
`default_nettype wire

// ==== pm_fund_reset.sv ====
// fundamental reset generation from PCIe reset and global reset
`timescale 1ns/1ps
`default_nettype none
module pm_fund_reset (
  input  wire logic mclk,
  input  wire logic perst_n,
  input  wire logic global_reset_n,
  output logic      fundamental_reset_n
);
  logic both_n;
  logic s1_q;
  logic s2_q;

  assign both_n = perst_n & global_reset_n;

  // asserts at once, releases after two clean edges to avoid a ragged release
  always_ff @(posedge mclk or negedge both_n) begin
    if (!both_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= 1'b1;
      s2_q <= s1_q;
    end
  end

  assign fundamental_reset_n = s2_q;
endmodule : pm_fund_reset
`default_nettype wire

// ==== pm_rd_mux.sv ====
// read-data assembly for the power-management configuration words
`timescale 1ns/1ps
`default_nettype none
module pm_rd_mux (
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [1:0]  power_state_field,
  input  wire logic [15:0] misc_low,
  output logic [31:0]      rd_word,
  output logic             rd_hit
);
  logic [15:0] pmcsr_word;
  logic [15:0] cap_word;
  logic [2:0]  pm_version;
  logic        hit_pmcsr;
  logic        hit_misc;
  logic        hit_cap;

  // bits 15-2 hardwired zero: wake flag, enable, scale, select, reserved
  assign pmcsr_word = {14'h0000, power_state_field};
  assign pm_version = misc_low[pm_cfg_pkg::BIT_PM_REV] ? pm_cfg_pkg::PM_VER_NEW
                                                        : pm_cfg_pkg::PM_VER_OLD;
  assign cap_word   = {pm_cfg_pkg::PM_CAP_UPPER, pm_version};

  // the 4Ah extension shares the dword with 48h and reads zero in the upper half
  assign hit_pmcsr = (cfg_addr == pm_cfg_pkg::PMCSR_OFS) || (cfg_addr == pm_cfg_pkg::PM_EXT_OFS);
  assign hit_misc  = (cfg_addr == pm_cfg_pkg::MISC_OFS);
  assign hit_cap   = (cfg_addr == pm_cfg_pkg::PM_CAP_OFS);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (hit_pmcsr) begin
      rd_word = {pm_cfg_pkg::PM_EXT_VALUE, pmcsr_word};
    end else if (hit_misc) begin
      rd_word = {16'h0000, misc_low};
    end else if (hit_cap) begin
      rd_word = {cap_word, 16'h0000};
    end else begin
      rd_hit = 1'b0;
    end
  end
endmodule : pm_rd_mux
`default_nettype wire
